// >>> bcs_pkg.sv
// Beep cadence sequencer: shared constants, register map and state type.
// Assumes a 100 MHz register clock and an APB slave with 32-bit data.
package bcs_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CONTROL  = 10'h0A0;
	localparam logic [9:0] IDX_REPEAT   = 10'h0A6;
	localparam logic [9:0] IDX_BURST    = 10'h0A7;
	localparam logic [9:0] IDX_SILENCE  = 10'h0A8;
	localparam logic [9:0] IDX_STATUS   = 10'h0A9;
	localparam int         ADDR_W       = 12;

	// Field positions
	localparam int         RUN_BIT      = 7;
	localparam int         REP_W        = 3;
	localparam int         DUR_W        = 6;
	localparam int         STAT_CYC_LSB = 0;
	localparam int         STAT_ST_LSB  = 6;

	// Values after reset
	localparam logic [2:0] RST_REPEAT   = 3'h0;
	localparam logic [5:0] RST_BURST    = 6'h02;
	localparam logic [5:0] RST_SILENCE  = 6'h01;

	// Repeat-count coding
	localparam logic [2:0] REP_INFINITE = 3'h7;
	localparam logic [2:0] REP_LAST_LIN = 3'h3;

	// Duration coding
	localparam logic [5:0] DUR_LIN_MAX  = 6'h14;
	localparam logic [5:0] DUR_STEP_MIN = 6'h19;
	localparam logic [5:0] DUR_STEP_MAX = 6'h3C;
	localparam logic [5:0] DUR_SIL_RSV  = 6'h3D;
	localparam logic [5:0] DUR_CONT     = 6'h3F;

	// Timing: one tick is 10 ms of the 100 MHz clock
	localparam int         TICK_MS      = 10;
	localparam int         CLK_KHZ      = 100000;
	localparam int         TICK_CYCLES  = TICK_MS * CLK_KHZ;
	localparam int         STEP_BASE_MS = 250;
	localparam int         STEP_MS      = 50;
	localparam logic [7:0] TICKS_BASE   = 8'(STEP_BASE_MS / TICK_MS);
	localparam logic [7:0] TICKS_STEP   = 8'(STEP_MS / TICK_MS);
	localparam logic [7:0] TICKS_MIN    = 8'h01;

	// Sequencer states
	typedef enum logic [1:0]
	{
		BCS_IDLE    = 2'b00,
		BCS_BURST   = 2'b01,
		BCS_SILENCE = 2'b10
	} bcs_state_t;

endpackage : bcs_pkg

// >>> bcs_tick_gen.sv
// Beep cadence sequencer: 10 ms tick divider.
// Assumes clear comes from logic on the same clock.
`timescale 1ns/1ps
module bcs_tick_gen
#(
	parameter int CYCLES = bcs_pkg::TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic clear,
	// Tick out, one cycle wide
	output logic      tick
);

	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic          tick_r;
	wire           wrap = (count_r == LAST);

	// Restart on clear so each phase begins on a full tick
	assign count_nxt = (clear || wrap) ? '0 : count_r + CW'(1);

	// Divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_r <= '0;
			tick_r  <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			tick_r  <= wrap && !clear;
		end
	end

	assign tick = tick_r;

endmodule : bcs_tick_gen

// >>> bcs_dur_decode.sv
// Beep cadence sequencer: duration code to tick count.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
module bcs_dur_decode
(
	// Code in
	input  wire logic [5:0] code,
	// Decoded duration
	output logic      [7:0] ticks,
	output logic            cont,
	output logic            rsvd
);

	// Code classes
	wire       in_lin  = (code != 6'h00) && (code <= bcs_pkg::DUR_LIN_MAX);
	wire       in_step = (code >= bcs_pkg::DUR_STEP_MIN) && (code <= bcs_pkg::DUR_STEP_MAX);
	wire [7:0] step8   = {2'h0, 6'(code - bcs_pkg::DUR_STEP_MIN)};
	wire [7:0] step_tk = 8'(bcs_pkg::TICKS_BASE + 8'(step8 * bcs_pkg::TICKS_STEP));

	// Reserved and zero codes get one tick, a safe short gap
	assign ticks = in_lin ? {2'h0, code}
	             : (in_step ? step_tk : bcs_pkg::TICKS_MIN);
	assign cont  = (code == bcs_pkg::DUR_CONT);
	assign rsvd  = !in_lin && !in_step && !cont;

endmodule : bcs_dur_decode

// >>> bcs_sequencer.sv
// Beep cadence sequencer: APB registers and the burst/silence state machine.
// Assumes the tone synthesiser sits on pclk and pulses zero_cross each
// time its waveform crosses zero; tone_en gates that synthesiser.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

// What this block does
// - 3-bit repeat code: 1,2,3,4,8,16,32 cycles
// - Code 111 repeats until run cleared
// - Burst codes 0x1-0x14 give 10 ms steps
// - Burst codes 0x15-0x18 reserved, undefined length; this block gives them one tick
// - Codes 0x19-0x3C: 250 ms plus 50 ms steps
// - Burst code all ones sounds continuously
// - Silence field uses same millisecond coding
// - Silence code 0x3D reserved, undefined length; this block gives it one tick
// - Silence code 0x3F means continuous silence
// - Run bit starts; device clears it when done
// - Clearing run finishes current beep cycle
// - Continuous tone stops at next zero crossing
module bcs_sequencer
#(
	parameter int TICK_CYCLES = bcs_pkg::TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [bcs_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Tone synthesiser side
	input  wire logic                      zero_cross,
	output logic                           tone_en,
	output logic                           seq_active
);

	// Registers
	logic                      run_r;
	logic                      run_nxt;
	logic [bcs_pkg::REP_W-1:0] rep_r;
	logic [bcs_pkg::DUR_W-1:0] burst_r;
	logic [bcs_pkg::DUR_W-1:0] sil_r;
	bcs_pkg::bcs_state_t       state_r;
	bcs_pkg::bcs_state_t       state_nxt;
	logic [7:0]                tick_cnt_r;
	logic [7:0]                tick_cnt_nxt;
	logic [5:0]                cyc_cnt_r;
	logic [5:0]                cyc_cnt_nxt;
	logic                      tone_en_r;
	logic                      active_r;
	logic [31:0]               prdata_r;
	logic                      pslverr_r;

	// Decoder and divider results
	logic [7:0]                burst_ticks;
	logic                      burst_cont;
	logic [7:0]                sil_ticks;
	logic                      sil_cont;
	logic                      tick_p;

	// APB decode
	wire [9:0] idx        = paddr[bcs_pkg::ADDR_W-1:2];
	wire       aligned    = (paddr[1:0] == 2'h0);
	wire       hit_ctrl   = aligned && (idx == bcs_pkg::IDX_CONTROL);
	wire       hit_rep    = aligned && (idx == bcs_pkg::IDX_REPEAT);
	wire       hit_burst  = aligned && (idx == bcs_pkg::IDX_BURST);
	wire       hit_sil    = aligned && (idx == bcs_pkg::IDX_SILENCE);
	wire       hit_stat   = aligned && (idx == bcs_pkg::IDX_STATUS);
	wire       addr_ok    = hit_ctrl || hit_rep || hit_burst || hit_sil || hit_stat;
	wire       setup_ph   = psel && !penable;
	wire       wr_access  = psel && penable && pwrite;
	wire       wr_ctrl    = wr_access && hit_ctrl;
	wire       wr_rep     = wr_access && hit_rep;
	wire       wr_burst   = wr_access && hit_burst;
	wire       wr_sil     = wr_access && hit_sil;

	// Read mux; reserved bits read as zero
	wire [7:0] rd_ctrl    = {run_r, 7'h00};
	wire [7:0] rd_rep     = {5'h00, rep_r};
	wire [7:0] rd_burst   = {2'h0, burst_r};
	wire [7:0] rd_sil     = {2'h0, sil_r};
	wire [7:0] rd_stat    = {state_r, cyc_cnt_r};
	wire [7:0] rd_byte    = ({8{hit_ctrl}} & rd_ctrl) | ({8{hit_rep}} & rd_rep)
	                      | ({8{hit_burst}} & rd_burst) | ({8{hit_sil}} & rd_sil)
	                      | ({8{hit_stat}} & rd_stat);

	// Duration fields decoded by one shared module each
	bcs_dur_decode u_burst_dec
	(
		.code  (burst_r),
		.ticks (burst_ticks),
		.cont  (burst_cont),
		.rsvd  ()
	);

	bcs_dur_decode u_sil_dec
	(
		.code  (sil_r),
		.ticks (sil_ticks),
		.cont  (sil_cont),
		.rsvd  ()
	);

	// Repeat target; infinite code has no target
	// Codes above the linear range double from eight: 4->8, 5->16, 6->32
	wire       rep_inf    = (rep_r == bcs_pkg::REP_INFINITE);
	wire [5:0] rep_target = (rep_r <= bcs_pkg::REP_LAST_LIN) ? 6'(rep_r + 3'h1)
	                      : 6'(6'h01 << (rep_r - 3'h1));

	// Phase ends and stop conditions
	wire       in_idle    = (state_r == bcs_pkg::BCS_IDLE);
	wire       in_burst   = (state_r == bcs_pkg::BCS_BURST);
	wire       in_sil     = (state_r == bcs_pkg::BCS_SILENCE);
	wire [8:0] tick_next  = {1'b0, tick_cnt_r} + 9'h001;
	wire       start_p    = in_idle && run_r;
	wire       burst_end  = in_burst && !burst_cont && tick_p
	                      && (tick_next >= {1'b0, burst_ticks});
	wire       zc_stop    = in_burst && burst_cont && !run_r && zero_cross;
	wire       sil_end    = in_sil && !sil_cont && tick_p
	                      && (tick_next >= {1'b0, sil_ticks});
	wire       sil_abort  = in_sil && sil_cont && !run_r;
	wire       last_cyc   = !rep_inf && ((cyc_cnt_r + 6'h01) == rep_target);
	wire       done_auto  = sil_end && last_cyc;
	wire       phase_clr  = start_p || burst_end || sil_end;

	// 10 ms tick, restarted at every phase boundary
	bcs_tick_gen
	#(
		.CYCLES (TICK_CYCLES)
	)
	u_tick
	(
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (phase_clr),
		.tick    (tick_p)
	);

	// Run bit: a software write of 1 wins over the hardware clear
	// Hardware clears it only at the end of the last counted silence
	assign run_nxt = wr_ctrl ? pwdata[bcs_pkg::RUN_BIT] : (done_auto ? 1'b0 : run_r);

	// Next state
	// Reserved codes never stall: the decoder maps them to one tick
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			bcs_pkg::BCS_IDLE:
			begin
				if (start_p)
					state_nxt = bcs_pkg::BCS_BURST;
			end
			bcs_pkg::BCS_BURST:
			begin
				if (zc_stop)
					state_nxt = bcs_pkg::BCS_IDLE;
				else if (burst_end)
					state_nxt = bcs_pkg::BCS_SILENCE;
			end
			bcs_pkg::BCS_SILENCE:
			begin
				if (sil_abort)
					state_nxt = bcs_pkg::BCS_IDLE;
				else if (sil_end && (last_cyc || !run_r))
					state_nxt = bcs_pkg::BCS_IDLE;
				else if (sil_end)
					state_nxt = bcs_pkg::BCS_BURST;
			end
			default:
				state_nxt = bcs_pkg::BCS_IDLE;
		endcase
	end

	// Tick and cycle counters; a fresh start zeroes both
	assign tick_cnt_nxt = phase_clr ? 8'h00 : (tick_p ? tick_next[7:0] : tick_cnt_r);
	assign cyc_cnt_nxt  = start_p ? 6'h00
	                    : ((sil_end && !rep_inf) ? cyc_cnt_r + 6'h01 : cyc_cnt_r);

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r    <= bcs_pkg::BCS_IDLE;
			tick_cnt_r <= 8'h00;
			cyc_cnt_r  <= 6'h00;
			tone_en_r  <= 1'b0;
			active_r   <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			cyc_cnt_r  <= cyc_cnt_nxt;
			tone_en_r  <= (state_nxt == bcs_pkg::BCS_BURST);
			active_r   <= (state_nxt != bcs_pkg::BCS_IDLE);
		end
	end

	// Software-visible registers; fields may change mid-sequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_r   <= 1'b0;
			rep_r   <= bcs_pkg::RST_REPEAT;
			burst_r <= bcs_pkg::RST_BURST;
			sil_r   <= bcs_pkg::RST_SILENCE;
		end
		else
		begin
			run_r <= run_nxt;
			if (wr_rep)
				rep_r <= pwdata[bcs_pkg::REP_W-1:0];
			if (wr_burst)
				burst_r <= pwdata[bcs_pkg::DUR_W-1:0];
			if (wr_sil)
				sil_r <= pwdata[bcs_pkg::DUR_W-1:0];
		end
	end

	// Read data and error latched in setup, so access needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (setup_ph)
		begin
			prdata_r  <= {24'h00_0000, rd_byte};
			pslverr_r <= !addr_ok;
		end
	end

	assign prdata     = prdata_r;
	assign pslverr    = pslverr_r;
	assign pready     = 1'b1;
	assign tone_en    = tone_en_r;
	assign seq_active = active_r;

	// Checks; reset masks them, so the first edge after release is quiet
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Decode checks: pure functions of the field registers, mixed with sequencing checks on the state
	a_rep_code_map: assert property (
		(rep_r == 3'h0 |-> rep_target == 6'h01) and (rep_r == 3'h3 |-> rep_target == 6'h04)
		and (rep_r == 3'h4 |-> rep_target == 6'h08) and (rep_r == 3'h5 |-> rep_target == 6'h10)
		and (rep_r == 3'h6 |-> rep_target == 6'h20))
		else $error("repeat code decode wrong");

	a_lin_codes: assert property (
		(burst_r == 6'h01 |-> burst_ticks == 8'h01)
		and (burst_r == 6'h14 |-> burst_ticks == 8'h14))
		else $error("linear burst code decode wrong");

	a_rsvd_burst: assert property (
		(burst_r >= 6'h15 && burst_r <= 6'h18) |-> (burst_ticks == 8'h01) && !burst_cont)
		else $error("reserved burst code would stall");

	a_sil_codes: assert property (
		(sil_r == 6'h14 |-> sil_ticks == 8'h14)
		and (sil_r == 6'h3C |-> sil_ticks == 8'hC8))
		else $error("silence code decode wrong");

	a_sil_rsvd: assert property (
		(sil_r == bcs_pkg::DUR_SIL_RSV) |-> (sil_ticks == 8'h01) && !sil_cont)
		else $error("reserved silence code would stall");

	a_inf_no_stop: assert property (
		(rep_inf && run_r && in_sil && sil_end && !wr_ctrl) |=> in_burst && run_r)
		else $error("infinite repeat stopped");

	a_burst_len: assert property (
		(in_burst && !burst_cont && tick_p && tick_next < {1'b0, burst_ticks}) |=> in_burst)
		else $error("burst ended early");

	a_step_codes: assert property (
		(burst_r == 6'h19 |-> burst_ticks == 8'd25)
		and (burst_r == 6'h3C |-> burst_ticks == 8'hC8))
		else $error("250 ms code decode wrong");

	a_cont_tone: assert property (
		(in_burst && burst_cont && run_r) |=> in_burst && tone_en)
		else $error("continuous tone left burst");

	a_sil_cont: assert property (
		(in_sil && sil_cont && run_r && !wr_ctrl) |=> in_sil && !tone_en)
		else $error("continuous silence left");

	a_run_autoclr: assert property (
		(done_auto && !wr_ctrl) |=> !run_r && in_idle && !seq_active)
		else $error("run bit not cleared on completion");

	a_finish_cycle: assert property (
		(in_burst && !burst_cont && !run_r && !burst_end) |=> !in_idle)
		else $error("stopped inside a timed burst");

	a_zero_stop: assert property (
		zc_stop |=> in_idle ##1 !tone_en)
		else $error("continuous tone missed zero crossing stop");

	a_cycle_adv: assert property (
		(sil_end && !rep_inf && !start_p) |=> (cyc_cnt_r == $past(cyc_cnt_r) + 6'h01))
		else $error("cycle count did not advance after silence");

	a_start_fresh: assert property (
		start_p |=> in_burst && tick_cnt_r == 8'h00 && cyc_cnt_r == 6'h00 && tone_en)
		else $error("sequence start did not restart timing");

	// Sequencing checks on the phase, the run bit, the tick and the outputs
	a_zc_wait: assert property (
		(in_burst && burst_cont && !zero_cross) |=> in_burst)
		else $error("continuous tone stopped without zero crossing");

	a_sil_abort: assert property (
		sil_abort |=> in_idle && !seq_active)
		else $error("continuous silence did not stop on run clear");

	a_run_hold: assert property (
		(!in_sil && run_r && !wr_ctrl) |=> run_r)
		else $error("run bit cleared outside a silence end");

	a_burst_sil: assert property (
		burst_end |=> in_sil && !tone_en)
		else $error("timed burst not followed by silence");

	a_phase_out: assert property (
		(tone_en == in_burst) && (seq_active == !in_idle))
		else $error("outputs disagree with the phase");

	a_tick_restart: assert property (
		phase_clr |=> !tick_p && (tick_cnt_r == 8'h00))
		else $error("phase start did not restart the tick");

endmodule : bcs_sequencer

// >>> tb.sv
// Testbench for the beep cadence sequencer: APB register tasks and cadence checks.
// Assumes the sequencer top with a shortened tick divider of ten clocks.
`timescale 1ns/1ps
module tb;
	localparam int T = 10;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        zero_cross = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tone_en;
	logic        seq_active;
	logic [31:0] rd;
	logic        err;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          bursts = 0;
	int          hi = 0;
	int          lo = 0;
	int          hi_len = 0;
	int          lo_len = 0;
	int          b0;

	bcs_sequencer #(.TICK_CYCLES(T)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .zero_cross(zero_cross), .tone_en(tone_en),
		.seq_active(seq_active));

	// 100 MHz clock
	initial
	begin
		forever #5 pclk = ~pclk;
	end

	// Burst count and phase lengths seen on the tone enable
	always @(posedge pclk)
	begin
		if (tone_en === 1'b1)
		begin
			hi <= hi + 1;
			if (hi == 0) bursts <= bursts + 1;
			if (lo != 0) lo_len <= lo;
			lo <= 0;
		end
		else
		begin
			if (hi != 0) hi_len <= hi;
			hi <= 0;
			if (seq_active === 1'b1) lo <= lo + 1;
			else if (lo != 0)
			begin
				lo_len <= lo;
				lo <= 0;
			end
		end
	end

	task automatic close_out;
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// Range check; divider restart may add a cycle or two per phase
	task automatic chk_len(input string nm, input int ticks, input int got);
		n_tests++;
		if (got < ticks * T || got > ticks * T + 2)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, ticks * T, got);
		end
	endtask : chk_len

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_idle(input int lim);
		int k;
		k = 0;
		// Let a just-written run bit reach the phase outputs first
		repeat (2) @(posedge pclk);
		while (seq_active !== 1'b0 && k < lim)
		begin
			@(posedge pclk);
			k++;
		end
		if (seq_active !== 1'b0)
		begin
			error_cnt++;
			close_out();
		end
		repeat (2) @(posedge pclk);
	endtask : wait_idle

	task automatic cfg(input logic [31:0] r, input logic [31:0] b, input logic [31:0] s);
		apb(1'b1, bcs_pkg::IDX_REPEAT, r);
		apb(1'b1, bcs_pkg::IDX_BURST, b);
		apb(1'b1, bcs_pkg::IDX_SILENCE, s);
		b0 = bursts;
		apb(1'b1, bcs_pkg::IDX_CONTROL, 32'h0000_0080);
	endtask : cfg

	int exp_cnt [7] = '{1, 2, 3, 4, 8, 16, 32};
	logic [5:0] bc [4] = '{6'h14, 6'h19, 6'h3C, 6'h02};
	logic [5:0] sc [4] = '{6'h19, 6'h01, 6'h14, 6'h3C};
	int bt [4] = '{20, 25, 200, 2};
	int st [4] = '{25, 1, 20, 200};

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped place
		apb(1'b0, bcs_pkg::IDX_CONTROL, 32'h0);
		chk("control", 32'h0000_0000, rd);
		apb(1'b0, bcs_pkg::IDX_REPEAT, 32'h0);
		chk("repeat", 32'h0000_0000, rd);
		apb(1'b0, bcs_pkg::IDX_BURST, 32'h0);
		chk("burst", 32'h0000_0002, rd);
		apb(1'b0, bcs_pkg::IDX_SILENCE, 32'h0);
		chk("silence", 32'h0000_0001, rd);
		apb(1'b0, 10'h0B0, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		// Every finite repeat code, then auto-clear of run
		for (int c = 0; c < 7; c++)
		begin
			cfg(32'(c), 32'h01, 32'h01);
			wait_idle(3000);
			chk("burst count", 32'(exp_cnt[c]), 32'(bursts - b0));
			apb(1'b0, bcs_pkg::IDX_CONTROL, 32'h0);
			chk("run cleared", 32'h0000_0000, rd);
		end
		// Linear and stepped duration codes for both fields
		for (int i = 0; i < 4; i++)
		begin
			cfg(32'h01, 32'(bc[i]), 32'(sc[i]));
			wait_idle(10000);
			chk_len("burst len", bt[i], hi_len);
			chk_len("silence len", st[i], lo_len);
		end
		// Endless repeat stops only after the cycle in progress
		cfg(32'h07, 32'h01, 32'h02);
		repeat (300) @(posedge pclk);
		chk("still running", 32'h1, {31'h0, seq_active});
		apb(1'b1, bcs_pkg::IDX_CONTROL, 32'h0);
		wait_idle(200);
		chk_len("final silence", 2, lo_len);
		// Continuous tone stops only at a zero crossing
		cfg(32'h00, 32'h3F, 32'h01);
		repeat (300) @(posedge pclk);
		chk("tone held", 32'h1, {31'h0, tone_en});
		apb(1'b0, bcs_pkg::IDX_STATUS, 32'h0);
		chk("status burst", 32'h0000_0040, rd);
		apb(1'b1, bcs_pkg::IDX_CONTROL, 32'h0);
		repeat (20) @(posedge pclk);
		chk("tone before zc", 32'h1, {31'h0, tone_en});
		zero_cross <= 1'b1;
		@(posedge pclk);
		zero_cross <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("tone after zc", 32'h0, {31'h0, tone_en});
		wait_idle(50);
		// Continuous silence holds until run is cleared
		cfg(32'h00, 32'h01, 32'h3F);
		repeat (300) @(posedge pclk);
		chk("silence held", 32'h1, {31'h0, seq_active & ~tone_en});
		apb(1'b1, bcs_pkg::IDX_CONTROL, 32'h0);
		wait_idle(10);
		// Reserved codes must still let the sequence complete
		cfg(32'h00, 32'h15, 32'h3D);
		wait_idle(500);
		chk("reserved bursts", 32'h1, 32'(bursts - b0));
		apb(1'b0, bcs_pkg::IDX_CONTROL, 32'h0);
		chk("reserved done", 32'h0000_0000, rd);
		// Reset in mid-sequence drops the outputs and the fields
		cfg(32'h07, 32'h01, 32'h01);
		repeat (40) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("reset tone", 32'h0, {31'h0, tone_en | seq_active});
		apb(1'b0, bcs_pkg::IDX_CONTROL, 32'h0);
		chk("reset run", 32'h0000_0000, rd);
		apb(1'b0, bcs_pkg::IDX_REPEAT, 32'h0);
		chk("reset repeat", 32'h0000_0000, rd);
		close_out();
	end
endmodule : tb
